// ---- hw/fault_status_pkg.sv ----
// constants and carrier types for the voltage fault status register pair
// assumes an upstream serial-bus engine that presents byte-wide register accesses
// Function
// - channels 4, 3 and 2 put their low-frequency undervoltage flags at bits 3, 2 and 1.
// - a low-frequency undervoltage flag sets when its channel level falls below its threshold while its channel interrupt enable is on.
// - channels 4, 3 and 2 put their high-frequency overvoltage flags at bits 3, 2 and 1.
// - a high-frequency overvoltage flag sets when its channel level rises above its threshold while its channel interrupt enable is on.
// - every flag stays set after recovery and only a host write of one may clear it.
// - a write of one clears an undervoltage flag only if the level is back at or above its threshold.
// - a write of one clears an overvoltage flag only if the level is back at or below its threshold.
// - an undervoltage flag reads zero while its channel interrupt enable is off.
// - an overvoltage flag reads zero while its channel interrupt enable is off.
// - both registers reset to zero and bits 7 to 4 and bit 0 always read zero.
// - the summary undervoltage low-frequency bit is the OR of the undervoltage register.
// - the summary overvoltage high-frequency bit is the OR of the overvoltage register.
package fault_status_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] LF_UNDERVOLT_STATUS_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] HF_OVERVOLT_STATUS_OFS = 8'h16;

    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    // flag bits 3..1 map to monitor channels 4..2
    localparam int CH_LO_BIT = 1;
    localparam int CH_HI_BIT = 3;
    localparam logic [DATA_W-1:0] FLAG_MASK = 8'h0E;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic wr;
        logic rd;
        logic [DATA_W-1:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] rdata;
    } reg_rsp_s;

endpackage

// ---- hw/uv_ov_fault_status_regs.sv ----
// sticky undervoltage (low-frequency) and overvoltage (high-frequency) fault status
// one sticky cell per channel and register; the top decodes, masks and answers
// reads answer one cycle after the strobe; summaries follow the flags one cycle later, in step with a read answer
// assumes the bus engine gives one-cycle wr/rd strobes and levels synchronous to clk
// threshold, enable registers and the serial transport sit outside this file
// no interrupt logic lives here; the enables only mask and gate the flags
`timescale 1ns/10ps
`default_nettype none

module uv_ov_fault_status_regs
    import fault_status_pkg::*;
#(
    parameter int LEVEL_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register access from bus engine
    input wire reg_req_s req,
    output reg_rsp_s rsp,
    // per-channel levels, index 3..1 = channels 4..2
    input wire logic [3:1][LEVEL_W-1:0] lf_monitor_level,
    input wire logic [3:1][LEVEL_W-1:0] lf_undervolt_threshold,
    input wire logic [3:1][LEVEL_W-1:0] hf_monitor_level,
    input wire logic [3:1][LEVEL_W-1:0] hf_overvolt_threshold,
    // interrupt enables from the enable registers
    input wire logic [3:1] lf_undervolt_irq_enable,
    input wire logic [3:1] hf_overvolt_irq_enable,
    // summary bits
    output logic uv_lf_summary,
    output logic ov_hf_summary
);

    // channel count follows the flag slice; the port arrays are fixed at three
    localparam int NCH = CH_HI_BIT - CH_LO_BIT + 1;

    // elaboration checks: refuse what the compare and the byte map cannot serve
    if (LEVEL_W < 1 || LEVEL_W > 32) begin : g_bad_width
        $error("LEVEL_W out of range");
    end
    if (CH_LO_BIT < 1 || CH_HI_BIT >= DATA_W) begin : g_bad_slice
        $error("flag slice does not fit the data byte");
    end
    if (NCH != 3) begin : g_bad_count
        $error("channel ports are sized for three channels");
    end
    if (ADDR_W != 8 || DATA_W != 8) begin : g_bad_bus
        $error("register port must be byte wide with byte addresses");
    end
    if (LF_UNDERVOLT_STATUS_OFS == HF_OVERVOLT_STATUS_OFS) begin : g_bad_ofs
        $error("the two status registers share an offset");
    end

    // clear requests per channel, already cut to the flag slice
    logic [3:1] uv_clr_req;
    logic [3:1] ov_clr_req;

    // stored flags, before the enable mask
    logic [3:1] lf_undervolt_flag;
    logic [3:1] hf_overvolt_flag;

    // decoded strobes
    logic uv_wr_hit;
    logic ov_wr_hit;
    logic uv_rd_hit;
    logic ov_rd_hit;

    // visible register bytes
    logic [DATA_W-1:0] uv_view;
    logic [DATA_W-1:0] ov_view;

    // read answer group
    reg_rsp_s rsp_q;
    reg_rsp_s rsp_d;

    // summary groups
    logic uv_sum_q;
    logic uv_sum_d;
    logic ov_sum_q;
    logic ov_sum_d;

    // byte map: channel n lands at bit n-1, everything else reads zero
    function automatic logic [DATA_W-1:0] place_flags(input logic [3:1] flags);
        logic [DATA_W-1:0] byte_v;
        byte_v = STATUS_RESET;
        byte_v[CH_HI_BIT:CH_LO_BIT] = flags;
        return byte_v;
    endfunction

    // the mask constant must agree with the byte map
    if (FLAG_MASK != place_flags(3'h7)) begin : g_bad_mask
        $error("flag mask disagrees with the byte map");
    end

    // write decode: exact 8-bit compare, other addresses never clear anything
    always_comb begin
        uv_wr_hit = req.wr && (req.addr == LF_UNDERVOLT_STATUS_OFS);
        ov_wr_hit = req.wr && (req.addr == HF_OVERVOLT_STATUS_OFS);
    end

    // read decode: other addresses still answer, with a zero byte
    always_comb begin
        uv_rd_hit = req.rd && (req.addr == LF_UNDERVOLT_STATUS_OFS);
        ov_rd_hit = req.rd && (req.addr == HF_OVERVOLT_STATUS_OFS);
    end

    // undervolt clear: ones in bits 3..1 ask, zeros and reserved bits do nothing
    always_comb begin
        uv_clr_req = '0;
        if (uv_wr_hit) begin
            uv_clr_req = req.wdata[CH_HI_BIT:CH_LO_BIT];
        end
    end

    // overvolt clear: same byte map as the undervolt register
    always_comb begin
        ov_clr_req = '0;
        if (ov_wr_hit) begin
            ov_clr_req = req.wdata[CH_HI_BIT:CH_LO_BIT];
        end
    end

    // undervolt cells trip strictly below their threshold
    for (genvar ch = CH_LO_BIT; ch <= CH_HI_BIT; ch++) begin : g_uv_chan
        fault_flag_cell #(
            .LEVEL_W(LEVEL_W),
            .TRIP_ABOVE(1'b0)
        ) i_fault_flag_cell (
            // clock and reset
            .clk(clk),
            .nrst(nrst),
            // channel level and limit
            .level(lf_monitor_level[ch]),
            .threshold(lf_undervolt_threshold[ch]),
            // register side
            .irq_enable(lf_undervolt_irq_enable[ch]),
            .clear_req(uv_clr_req[ch]),
            // stored flag
            .flag(lf_undervolt_flag[ch])
        );
    end

    // overvolt cells trip strictly above their threshold
    for (genvar ch = CH_LO_BIT; ch <= CH_HI_BIT; ch++) begin : g_ov_chan
        fault_flag_cell #(
            .LEVEL_W(LEVEL_W),
            .TRIP_ABOVE(1'b1)
        ) i_fault_flag_cell (
            // clock and reset
            .clk(clk),
            .nrst(nrst),
            // channel level and limit
            .level(hf_monitor_level[ch]),
            .threshold(hf_overvolt_threshold[ch]),
            // register side
            .irq_enable(hf_overvolt_irq_enable[ch]),
            .clear_req(ov_clr_req[ch]),
            // stored flag
            .flag(hf_overvolt_flag[ch])
        );
    end

    // reserved bits stay zero and a disabled channel reads zero
    always_comb begin
        uv_view = place_flags(lf_undervolt_flag
            & lf_undervolt_irq_enable);
    end

    // the mask only hides a stored flag; enabling the channel again shows it
    always_comb begin
        ov_view = place_flags(hf_overvolt_flag
            & hf_overvolt_irq_enable);
    end

    // read answer: c0 strobe taken, c1 valid and data, c2 back to zero
    // a read and a write in one cycle return the flags from before the write
    always_comb begin
        // any read is answered, mapped or not
        rsp_d.valid = req.rd;
        rsp_d.rdata = STATUS_RESET;
        case ({uv_rd_hit, ov_rd_hit})
            2'h2: rsp_d.rdata = uv_view;
            2'h1: rsp_d.rdata = ov_view;
            default: rsp_d.rdata = STATUS_RESET;
        endcase
    end

    // one flop stage, so rdata is zero outside the valid pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rsp_q.valid <= 1'b0;
            rsp_q.rdata <= STATUS_RESET;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    // summaries lag the visible bytes one cycle so that they leave from flops
    always_comb begin
        uv_sum_d = |uv_view;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            uv_sum_q <= 1'b0;
        end else begin
            uv_sum_q <= uv_sum_d;
        end
    end

    // masked flags do not count towards the summary
    always_comb begin
        ov_sum_d = |ov_view;
    end

    // reset clears the summary together with its flags
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ov_sum_q <= 1'b0;
        end else begin
            ov_sum_q <= ov_sum_d;
        end
    end

    assign rsp = rsp_q;
    assign uv_lf_summary = uv_sum_q;
    assign ov_hf_summary = ov_sum_q;

endmodule

// one sticky fault flag: sets on its trip condition while irq_enable is high, clears on a granted write of one
// the compare is unsigned; level and limit are plain codes of one scale
module fault_flag_cell
    import fault_status_pkg::*;
#(
    parameter int LEVEL_W = 8,
    parameter bit TRIP_ABOVE = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // level and limit of one channel
    input wire logic [LEVEL_W-1:0] level,
    input wire logic [LEVEL_W-1:0] threshold,
    // control from the register side
    input wire logic irq_enable,
    input wire logic clear_req,
    // stored flag
    output logic flag
);

    if (LEVEL_W < 1 || LEVEL_W > 32) begin : g_bad_width
        $error("LEVEL_W out of range");
    end

    // trip, grant and set terms
    logic below;
    logic above;
    logic cond;
    logic clear_ok;
    logic set_now;
    logic flag_q;
    logic flag_d;

    // strict compare: a level equal to its limit is never a fault
    always_comb begin
        below = level < threshold;
        above = level > threshold;
    end

    // pick the trip direction for this cell
    always_comb begin
        cond = TRIP_ABOVE ? above : below;
        // a clear is granted only once the level is no longer past its limit
        clear_ok = clear_req && !cond;
        set_now = cond && irq_enable;
    end

    // set wins over a granted clear in the same cycle
    // a disabled channel neither latches nor shows a new fault
    always_comb begin
        flag_d = flag_q;
        if (clear_ok) begin
            flag_d = 1'b0;
        end
        if (set_now) begin
            flag_d = 1'b1;
        end
    end

    // nothing but a granted clear or reset drops the flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;

endmodule

`default_nettype wire

// ---- test/fault_status_props.sv ----
// concurrent checks on the voltage fault status register pair
// assumes it is bound onto uv_ov_fault_status_regs and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module fault_status_props
    import fault_status_pkg::*;
(
    // watched ports
    input wire logic clk,
    input wire logic nrst,
    input wire reg_req_s req,
    input wire reg_rsp_s rsp,
    input wire logic [3:1] lf_undervolt_irq_enable,
    input wire logic [3:1] hf_overvolt_irq_enable,
    input wire logic uv_lf_summary,
    input wire logic ov_hf_summary
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_rsvd_zero: assert property (rsp.valid |-> !(rsp.rdata & ~FLAG_MASK))
        else $error("reserved status bits read nonzero");
    a_uv_mask: assert property (req.rd && req.addr == LF_UNDERVOLT_STATUS_OFS
        |=> rsp.valid && !(rsp.rdata[3:1] & ~$past(lf_undervolt_irq_enable)))
        else $error("uv mask");
    a_ov_mask: assert property (req.rd && req.addr == HF_OVERVOLT_STATUS_OFS
        |=> rsp.valid && !(rsp.rdata[3:1] & ~$past(hf_overvolt_irq_enable)))
        else $error("ov mask");
    a_uv_sum: assert property (rsp.valid && $past(req.addr) == LF_UNDERVOLT_STATUS_OFS
        |-> uv_lf_summary == |rsp.rdata) else $error("uv summary differs from register");
    a_ov_sum: assert property (rsp.valid && $past(req.addr) == HF_OVERVOLT_STATUS_OFS
        |-> ov_hf_summary == |rsp.rdata) else $error("ov summary differs from register");
    // without a write in between, a set flag may not vanish
    a_uv_stick: assert property (!req.wr ##1 uv_lf_summary && $stable(lf_undervolt_irq_enable)
        |=> uv_lf_summary) else $error("uv flag lost without write");
    a_ov_stick: assert property (!req.wr ##1 ov_hf_summary && $stable(hf_overvolt_irq_enable)
        |=> ov_hf_summary) else $error("ov flag lost without write");
    a_rd_answer: assert property (req.rd |=> rsp.valid) else $error("read not answered");
endmodule
bind uv_ov_fault_status_regs fault_status_props i_fault_status_props (.*);
`default_nettype wire

// ---- test/host_model.sv ----
// host side of the register port: one strobed byte access at a time
// assumes the answer is sampled at the edge after the strobe is taken
`timescale 1ns/10ps
`default_nettype none
module host_model
    import fault_status_pkg::*;
(
    // register port
    input wire logic clk,
    output reg_req_s req,
    input wire reg_rsp_s rsp
);
    initial req = '0;
    // released lines show inverted values so stale data never looks valid
    task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge clk) req <= '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge clk) req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
        @(posedge clk) q = rsp.valid ? rsp.rdata : 8'hEE;
    endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// random self-checking bench for the fault status register pair
// assumes host_model drives the register port and the checker is bound in
`timescale 1ns/10ps
`default_nettype none
module tb;
    import fault_status_pkg::*;
    logic clk = 0, nrst = 0, us, os;
    logic [3:1] ue = 0, oe = 0, eu = 0, eo = 0, bu, bo;
    logic [3:1][7:0] ul = 0, ut = 0, ol = 0, ot = 0;
    logic [7:0] q, w = 0, a;
    int miscompares = 0, compares = 0;
    reg_req_s req;
    reg_rsp_s rsp;
    uv_ov_fault_status_regs i_uv_ov_fault_status_regs (.clk(clk), .nrst(nrst), .req(req),
        .rsp(rsp), .lf_monitor_level(ul), .lf_undervolt_threshold(ut), .hf_monitor_level(ol),
        .hf_overvolt_threshold(ot), .lf_undervolt_irq_enable(ue), .hf_overvolt_irq_enable(oe),
        .uv_lf_summary(us), .ov_hf_summary(os));
    host_model i_host_model (.clk(clk), .req(req), .rsp(rsp));
    function automatic logic [3:1] lt(input logic [3:1][7:0] x, y);
        for (int i = 1; i < 4; i++) lt[i] = x[i] < y[i];
    endfunction
    task automatic check(input logic [7:0] s, e);
        compares++;
        if (s !== e) $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        miscompares += int'(s !== e);
    endtask
    task automatic conclude;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial forever #10 clk = ~clk;
    initial begin
        #200000 miscompares++;
        conclude();
    end
    initial begin
        q = 8'($urandom(50));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            i_host_model.access(1'b0, 8'h14 + 8'(i), w, q);
            check(q, STATUS_RESET);
        end
        $display("reset test done");
        repeat (300) begin
            @(posedge clk);
            // bytes from 00/01/80/81 hit equality and the top-bit boundary
            {ul, ut, ol, ot} <= {$urandom, $urandom, $urandom} & {4{24'h818181}};
            {ue, oe} <= 6'($urandom);
            w = 8'($urandom);
            a = 8'h14 + 8'($urandom % 3);
            i_host_model.access(1'b1, a, w, q);
            bu = lt(ul, ut);
            bo = lt(ot, ol);
            eu = eu & ~(a == 8'h14 ? w[3:1] & ~bu : 3'h0) | bu & ue;
            eo = eo & ~(a == 8'h16 ? w[3:1] & ~bo : 3'h0) | bo & oe;
            i_host_model.access(1'b0, LF_UNDERVOLT_STATUS_OFS, w, q);
            check(q, {4'h0, eu & ue, 1'b0});
            i_host_model.access(1'b0, HF_OVERVOLT_STATUS_OFS, w, q);
            check(q, {4'h0, eo & oe, 1'b0});
            check({7'h0, us}, {7'h0, |(eu & ue)});
            check({7'h0, os}, {7'h0, |(eo & oe)});
        end
        $display("random test done");
        conclude();
    end
endmodule
`default_nettype wire
